// *** design/waveform_timer.v ***
// 8-bit timer/counter with one compare channel and four waveform modes
//
// Behaviour
// - Normal mode counts up, wraps FF to 00
// - Normal overflow flag sets when count becomes zero
// - Normal mode accepts counter writes any time
// - Clear mode resets count on compare equal
// - Clear mode compare writes are unbuffered
// - Clear mode raises match flag the tick after top
// - Clear mode toggle action inverts output
// - Clear mode overflow sets on FF to 00 by counting, not on a clear from an FF match
// - Fast PWM counts bottom to max, restarts
// - Fast PWM clear/set on match, opposite at bottom
// - Fast PWM overflow sets on the max to bottom wrap
// - Fast PWM extreme compare: spike or constant
// - Fast PWM toggle gives half duty
// - Phase PWM up, turn at max with no hold, down
// - Phase PWM clear up-match, set down-match
// - Phase PWM overflow sets at bottom
// - Phase PWM extremes hold output constant
// - Phase PWM period start takes up-result
// - Pin driven only when direction is output
// - Tick from prescale factors 1..1024
// - Tick enables I/O clock or oscillator
// - Match flag sets tick after match
// - PWM compare writes buffered to top/bottom
// - Counter write beats clear and count
// - Counter write blocks next tick's match
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "timer_map.vh"
module waveform_timer (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Register port
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata_r,
    // Oscillator edge enable for asynchronous mode
    input  wire       osc_en,
    // Compare output pin
    output reg        pin_out_r,
    output reg        pin_oe_r,
    // Flags for an outside interrupt controller
    output reg        overflow_flag_r,
    output reg        match_flag_r
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [1:0] waveform_mode_field_r;  // Counting sequence selection
    reg  [1:0] output_action_field_r;  // Output action selection
    reg  [2:0] sel_r;                  // Prescale selection
    reg        dir_r;                  // Pin direction: 1 drives
    reg        async_r;                // Tick source is the oscillator
    reg  [7:0] count_value_r;          // Counter
    reg  [7:0] count_value_nxt;        // Counter next value
    reg  [7:0] compare_value_r;        // Active compare value
    reg  [7:0] compare_buf_r;          // Buffered compare value for PWM
    reg        down_r;                 // Phase PWM counting down
    reg        down_nxt;               // Direction next value
    reg        block_r;                // Match blocked after counter write
    reg        match_pend_r;           // Match seen, flag on next tick
    reg        ovf_set;                // Overflow condition this tick
    wire       timer_tick;             // One-cycle timer tick enable
    wire       src_en;                 // Source enable feeding prescaler
    wire       level;                  // Internal compare output state
    wire       is_pwm;                 // Either PWM mode
    wire       raw_eq;                 // Comparator equal
    wire       match;                  // Comparator match after blocking
    wire       wr_ctrl;                // Control write
    wire       wr_count;               // Counter write
    wire       wr_cmp;                 // Compare write
    wire       wr_flags;               // Flag clear write
    wire       wr_pin;                 // Pin register write
    wire       force_cmp;              // Forced compare strobe
    wire [7:0] count_inc;              // Counter plus one
    wire [7:0] count_dec;              // Counter minus one

    assign is_pwm    = (waveform_mode_field_r == `MODE_FAST) || (waveform_mode_field_r == `MODE_PCPWM);
    assign wr_ctrl   = wr && (addr == `ADDR_CTRL);
    assign wr_count  = wr && (addr == `ADDR_COUNT);
    assign wr_cmp    = wr && (addr == `ADDR_COMPARE);
    assign wr_flags  = wr && (addr == `ADDR_FLAGS);
    assign wr_pin    = wr && (addr == `ADDR_PIN);
    assign force_cmp = wr_ctrl && wdata[`CTRL_FORCE_BIT];
    assign count_inc = count_value_r + 8'h01;
    assign count_dec = count_value_r - 8'h01;
    assign raw_eq    = (count_value_r == compare_value_r);
    assign match     = raw_eq && !block_r;
    // Oscillator edges stand in for the I/O clock; the oscillator domain itself is not modelled
    assign src_en    = async_r ? osc_en : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Tick source
    tick_prescaler u_prescaler (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_en (src_en),
        .sel    (sel_r),
        .tick_r (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Waveform generator
    compare_output u_output (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (timer_tick),
        .mode      (waveform_mode_field_r),
        .action    (output_action_field_r),
        .count     (count_value_r),
        .down      (down_r),
        .cmp       (compare_value_r),
        .match     (match),
        .force_cmp (force_cmp),
        .level_r   (level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counting sequence and overflow condition per mode
    always @* begin
        count_value_nxt = count_value_r;
        down_nxt        = down_r;
        ovf_set         = 1'b0;
        case (waveform_mode_field_r)
            `MODE_NORMAL: begin
                count_value_nxt = count_inc;
                // Flag goes up with the tick that makes the count zero
                ovf_set = (count_value_r == `COUNT_MAX);
            end
            `MODE_CLEAR: begin
                if (match) begin
                    count_value_nxt = `COUNT_BOTTOM;
                end else begin
                    // A compare below the count wraps through max first
                    count_value_nxt = count_inc;
                end
                ovf_set = (count_value_r == `COUNT_MAX) && !match;
            end
            `MODE_FAST: begin
                // Increment wraps max to bottom on the next tick
                count_value_nxt = count_inc;
                ovf_set = (count_value_r == `COUNT_MAX);
            end
            `MODE_PCPWM: begin
                if (!down_r) begin
                    if (count_value_r == `COUNT_MAX) begin
                        // Max stands for one tick before the turn
                        down_nxt        = 1'b1;
                        count_value_nxt = count_dec;
                    end else begin
                        count_value_nxt = count_inc;
                    end
                end else if (count_value_r == `COUNT_BOTTOM) begin
                    down_nxt        = 1'b0;
                    count_value_nxt = count_inc;
                end else begin
                    count_value_nxt = count_dec;
                end
                ovf_set = down_r && (count_value_r == 8'h01);
            end
            default: begin
                count_value_nxt = count_value_r;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, direction and match blocking
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value_r <= `COUNT_RESET;
            down_r        <= 1'b0;
            block_r       <= 1'b0;
        end else begin
            if (wr_count) begin
                // Software write wins over clear and count in any mode
                count_value_r <= wdata;
                block_r       <= 1'b1;
            end else if (timer_tick) begin
                count_value_r <= count_value_nxt;
                down_r        <= down_nxt;
                block_r       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare register: direct in non-PWM modes, buffered in PWM modes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_value_r <= `COMPARE_RESET;
            compare_buf_r   <= `COMPARE_RESET;
        end else begin
            if (wr_cmp) begin
                compare_buf_r <= wdata;
            end
            if (!is_pwm) begin
                if (wr_cmp) begin
                    compare_value_r <= wdata;
                end
            end else if (timer_tick) begin
                // Fast PWM loads at max, phase PWM at max turn
                if (count_value_r == `COUNT_MAX && !down_r) begin
                    compare_value_r <= compare_buf_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and pin registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveform_mode_field_r <= `MODE_NORMAL;
            output_action_field_r <= 2'h0;
            sel_r                 <= `SEL_STOP;
            dir_r                 <= 1'b0;
            async_r               <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                waveform_mode_field_r <= wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
                output_action_field_r <= wdata[`CTRL_ACT_MSB:`CTRL_ACT_LSB];
                sel_r                 <= wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
            end
            if (wr_pin) begin
                dir_r   <= wdata[`PIN_DIR_BIT];
                async_r <= wdata[`PIN_ASYNC_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: hardware set wins over a software write-one clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_r <= 1'b0;
            match_flag_r    <= 1'b0;
            match_pend_r    <= 1'b0;
        end else begin
            if (timer_tick) begin
                match_pend_r <= match;
            end
            if (timer_tick && ovf_set) begin
                overflow_flag_r <= 1'b1;
            end else if (wr_flags && wdata[`FLAG_OVF_BIT]) begin
                overflow_flag_r <= 1'b0;
            end
            if (timer_tick && match_pend_r) begin
                match_flag_r <= 1'b1;
            end else if (wr_flags && wdata[`FLAG_MATCH_BIT]) begin
                match_flag_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and read port
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
            rdata_r   <= 8'h00;
        end else begin
            // State is kept internally; the pin shows it only when driven
            pin_out_r <= level & dir_r;
            pin_oe_r  <= dir_r;
            if (rd) begin
                case (addr)
                    `ADDR_CTRL:    rdata_r <= {1'b0, sel_r, output_action_field_r, waveform_mode_field_r};
                    `ADDR_COUNT:   rdata_r <= count_value_r;
                    `ADDR_COMPARE: rdata_r <= is_pwm ? compare_buf_r : compare_value_r;
                    `ADDR_FLAGS:   rdata_r <= {6'h00, match_flag_r, overflow_flag_r};
                    `ADDR_PIN:     rdata_r <= {5'h00, level, async_r, dir_r};
                    default:       rdata_r <= 8'h00;
                endcase
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end
endmodule // waveform_timer

// *** include/timer_map.vh ***
// Register offsets, field positions, reset values and mode codes of the waveform timer
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// Register offsets (word addresses on the plain port)
`define ADDR_CTRL      4'h0
`define ADDR_COUNT     4'h1
`define ADDR_COMPARE   4'h2
`define ADDR_FLAGS     4'h3
`define ADDR_PIN       4'h4
// Control register fields
`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  1
`define CTRL_ACT_LSB   2
`define CTRL_ACT_MSB   3
`define CTRL_SEL_LSB   4
`define CTRL_SEL_MSB   6
`define CTRL_FORCE_BIT 7
// Flag register fields
`define FLAG_OVF_BIT   0
`define FLAG_MATCH_BIT 1
// Pin register fields
`define PIN_DIR_BIT    0
`define PIN_ASYNC_BIT  1
// Reset values
`define CTRL_RESET     8'h00
`define COUNT_RESET    8'h00
`define COMPARE_RESET  8'h00
// Waveform modes
`define MODE_NORMAL    2'h0
`define MODE_PCPWM     2'h1
`define MODE_CLEAR     2'h2
`define MODE_FAST      2'h3
// Output actions
`define ACT_NONE       2'h0
`define ACT_TOGGLE     2'h1
`define ACT_CLEAR      2'h2
`define ACT_SET        2'h3
// Counter extremes
`define COUNT_MAX      8'hFF
`define COUNT_BOTTOM   8'h00
// Tick source selection codes
`define SEL_STOP       3'h0
`define SEL_DIV1       3'h1
`define SEL_DIV8       3'h2
`define SEL_DIV32      3'h3
`define SEL_DIV64      3'h4
`define SEL_DIV128     3'h5
`define SEL_DIV256     3'h6
`define SEL_DIV1024    3'h7
`endif

// *** design/tick_prescaler.v ***
// Prescaler that turns the source clock into a one-cycle timer tick enable
`timescale 1ns/10ps
`include "timer_map.vh"
module tick_prescaler (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Source enable: every cycle, or an oscillator edge in asynchronous mode
    input  wire       src_en,
    // Prescale selection
    input  wire [2:0] sel,
    // Tick out
    output reg        tick_r
);
    reg  [9:0] div_r;     // Free divider on the source rate
    reg        hit;       // Divider reaches the selected ratio boundary
    wire [9:0] div_inc;   // Incremented divider

    assign div_inc = div_r + 10'h001;

    // Ratio decode: all ones in the low bits marks the last source edge of a period
    always @* begin
        case (sel)
            `SEL_DIV1:    hit = 1'b1;
            `SEL_DIV8:    hit = &div_r[2:0];
            `SEL_DIV32:   hit = &div_r[4:0];
            `SEL_DIV64:   hit = &div_r[5:0];
            `SEL_DIV128:  hit = &div_r[6:0];
            `SEL_DIV256:  hit = &div_r[7:0];
            `SEL_DIV1024: hit = &div_r[9:0];
            default:      hit = 1'b0;
        endcase
    end

    // Divider and tick; stop selection holds the tick low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 10'h000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= src_en & hit;
            if (src_en) begin
                div_r <= div_inc;
            end
        end
    end
endmodule // tick_prescaler

// *** design/compare_output.v ***
// Waveform generator holding the compare output state for all four modes
`timescale 1ns/10ps
`include "timer_map.vh"
module compare_output (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Counter context
    input  wire       tick,
    input  wire [1:0] mode,
    input  wire [1:0] action,
    input  wire [7:0] count,
    input  wire       down,
    input  wire [7:0] cmp,
    input  wire       match,
    input  wire       force_cmp,
    // Output state
    output reg        level_r
);
    reg nxt; // Next output level

    // Output action per mode; match is already blocked after a counter write
    always @* begin
        nxt = level_r;
        if (force_cmp && (mode == `MODE_NORMAL || mode == `MODE_CLEAR)) begin
            // Forced compare acts like a match in non-PWM modes
            case (action)
                `ACT_TOGGLE: nxt = ~level_r;
                `ACT_CLEAR:  nxt = 1'b0;
                `ACT_SET:    nxt = 1'b1;
                default:     nxt = level_r;
            endcase
        end else if (tick) begin
            case (mode)
                `MODE_NORMAL, `MODE_CLEAR: begin
                    if (match) begin
                        case (action)
                            `ACT_TOGGLE: nxt = ~level_r;
                            `ACT_CLEAR:  nxt = 1'b0;
                            `ACT_SET:    nxt = 1'b1;
                            default:     nxt = level_r;
                        endcase
                    end
                end
                `MODE_FAST: begin
                    // Match wins at max so a max compare gives a steady level
                    if (action == `ACT_TOGGLE && match) begin
                        nxt = ~level_r;
                    end else if (action[1] && match) begin
                        nxt = action[0];
                    end else if (action[1] && count == `COUNT_MAX) begin
                        nxt = ~action[0];
                    end
                end
                `MODE_PCPWM: begin
                    if (action[1]) begin
                        if (count == `COUNT_MAX) begin
                            // Up result at max unless max is the compare
                            nxt = (cmp == `COUNT_MAX) ? ~action[0] : action[0];
                        end else if (match) begin
                            // Bottom match counts as up so a zero compare stays steady
                            nxt = (down && count != `COUNT_BOTTOM) ? ~action[0] : action[0];
                        end
                    end
                end
                default: nxt = level_r;
            endcase
        end
    end

    // Output state is kept across mode changes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
        end else begin
            level_r <= nxt;
        end
    end
endmodule // compare_output

// *** test/pin_load.sv ***
// External load on the compare output pin, with a pull-down resistor
`timescale 1ns/10ps
module pin_load (
    // Pin as the timer drives it
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // Level seen by the load
    output wire logic level
);
    // A released pin falls to the pull-down and never keeps the last driven value
    assign level = pin_oe ? pin_out : 1'h0;
endmodule // pin_load

// *** test/waveform_timer_sva.sv ***
// Port assertions for the waveform timer
`timescale 1ns/10ps
`include "timer_map.vh"
module timer_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata_r,
    // Oscillator enable, pin and flags
    input wire logic       osc_en,
    input wire logic       pin_out_r,
    input wire logic       pin_oe_r,
    input wire logic       overflow_flag_r,
    input wire logic       match_flag_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Count write followed at once by a count read
    sequence s_cnt_wr_rd;
        wr && addr == `ADDR_COUNT ##1 rd && addr == `ADDR_COUNT;
    endsequence
    // Direction write not overridden in the next cycle
    sequence s_dir_wr;
        wr && addr == `ADDR_PIN ##1 !(wr && addr == `ADDR_PIN);
    endsequence
    ////////////////////////////////////////
    property p_rd_idle; !rd |=> rdata_r == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_unmapped; rd && addr > `ADDR_PIN |=> rdata_r == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_force_rd; rd && addr == `ADDR_CTRL |=> !rdata_r[`CTRL_FORCE_BIT]; endproperty
    a_force_rd: assert property (p_force_rd) else $error("force strobe reads back high");
    property p_flags_rd; rd && addr == `ADDR_FLAGS |=> rdata_r[7:2] == 6'h00; endproperty
    a_flags_rd: assert property (p_flags_rd) else $error("unused flag bits read high");
    property p_cnt_wr; s_cnt_wr_rd |=> rdata_r == $past(wdata, 2); endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost to counting");
    property p_pin_gate; pin_out_r |-> pin_oe_r; endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven high while released");
    property p_dir; s_dir_wr |=> {7'h00, pin_oe_r} == ($past(wdata, 2) & 8'h01); endproperty
    a_dir: assert property (p_dir) else $error("pin enable does not follow direction");
    // Hardware only sets the flags; only a write of one clears them
    property p_ovf_hold; overflow_flag_r && !(wr && addr == `ADDR_FLAGS && wdata[0]) |=> overflow_flag_r; endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared by hardware");
    property p_mat_hold; match_flag_r && !(wr && addr == `ADDR_FLAGS && wdata[1]) |=> match_flag_r; endproperty
    a_mat_hold: assert property (p_mat_hold) else $error("match flag cleared by hardware");
endmodule // timer_checker

bind waveform_timer timer_checker u_timer_checker (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .osc_en(osc_en), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
    .overflow_flag_r(overflow_flag_r), .match_flag_r(match_flag_r)
);

// *** test/tb.sv ***
// Self-checking testbench for the waveform timer
`timescale 1ns/10ps
`include "timer_map.vh"
module tb;
    logic       clk, rst_n, wr, rd, osc_en;      // Clock, reset, strobes, oscillator edge
    logic [3:0] addr;                            // Register address
    logic [7:0] wdata, rdata_r;                  // Register data
    logic       pin_out_r, pin_oe_r, level;      // Pin and level at the load
    logic       overflow_flag_r, match_flag_r;   // Sticky flags
    int         bad_count, compares;             // Verdict counters
    int         fac [6] = '{8, 32, 64, 128, 256, 1024}; // Factors for selections 2..7

    waveform_timer u_waveform_timer (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .osc_en(osc_en), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
        .overflow_flag_r(overflow_flag_r), .match_flag_r(match_flag_r));
    pin_load u_pin_load (.pin_out(pin_out_r), .pin_oe(pin_oe_r), .level(level));

    // 250 MHz clock
    initial clk = 1'h0;
    always #2 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] got;
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 got = rdata_r;
        @(posedge clk);
        chk(what, exp, got);
    endtask
    task automatic cf(input logic [7:0] cnt, input logic [7:0] flg);
        rchk("count", `ADDR_COUNT, cnt);
        rchk("flags", `ADDR_FLAGS, flg);
    endtask
    task automatic pchk(input logic exp);
        chk("pin", {7'h00, exp}, {7'h00, level});
    endtask
    // One oscillator edge per tick in asynchronous mode keeps tick counts exact
    task automatic step(input int n);
        repeat (n) begin
            osc_en <= 1'h1;
            @(posedge clk);
            osc_en <= 1'h0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic set_mode(input logic [1:0] m, input logic [1:0] a, input logic [2:0] s);
        wr_reg(`ADDR_CTRL, {1'h0, s, a, m});
    endtask
    // Stopped normal mode so the compare write goes straight to the active value
    task automatic prep(input logic [7:0] cmp, input logic [7:0] cnt);
        set_mode(`MODE_NORMAL, `ACT_NONE, `SEL_STOP);
        wr_reg(`ADDR_COMPARE, cmp);
        wr_reg(`ADDR_COUNT, cnt);
        wr_reg(`ADDR_FLAGS, 8'h03);
    endtask
    ////////////////////////////////////////
    task automatic t_prescale;
        wr_reg(`ADDR_PIN, 8'h03);
        for (int i = 0; i < 6; i++) begin
            prep(8'h80, 8'h00);
            set_mode(`MODE_NORMAL, `ACT_NONE, 3'(i + 2));
            step(fac[i]);
            rchk("count", `ADDR_COUNT, 8'h01);
        end
    endtask
    task automatic t_normal;
        prep(8'h05, 8'h05);
        set_mode(`MODE_NORMAL, `ACT_NONE, `SEL_DIV1);
        step(2);
        cf(8'h07, 8'h00);
        wr_reg(`ADDR_COUNT, 8'hFE);
        step(1);
        cf(8'hFF, 8'h00);
        step(1);
        cf(8'h00, 8'h01);
        wr_reg(`ADDR_COUNT, 8'h04);
        wr_reg(`ADDR_FLAGS, 8'h03);
        step(1);
        cf(8'h05, 8'h00);
        step(2);
        cf(8'h07, 8'h02);
    endtask
    task automatic t_clear;
        logic p0;
        prep(8'h03, 8'h00);
        set_mode(`MODE_CLEAR, `ACT_TOGGLE, `SEL_DIV1);
        p0 = level;
        step(3);
        rchk("count", `ADDR_COUNT, 8'h03);
        step(1);
        rchk("count", `ADDR_COUNT, 8'h00);
        pchk(~p0);
        step(1);
        cf(8'h01, 8'h02);
        wr_reg(`ADDR_COUNT, 8'h05);
        wr_reg(`ADDR_COMPARE, 8'h02);
        step(250);
        rchk("count", `ADDR_COUNT, 8'hFF);
        step(1);
        cf(8'h00, 8'h03);
    endtask
    task automatic t_fast(input logic [1:0] a);
        prep(8'h02, 8'h00);
        set_mode(`MODE_FAST, a, `SEL_DIV1);
        step(3);
        pchk(a[0]);
        wr_reg(`ADDR_COMPARE, 8'h80);
        rchk("compare", `ADDR_COMPARE, 8'h80);
        step(253);
        cf(8'h00, 8'h03);
        pchk(~a[0]);
        step(3);
        pchk(~a[0]);
    endtask
    task automatic t_phase(input logic [1:0] a);
        prep(8'h02, 8'h00);
        set_mode(`MODE_PCPWM, a, `SEL_DIV1);
        wr_reg(`ADDR_COMPARE, 8'h02);
        step(3);
        pchk(a[0]);
        step(252);
        rchk("count", `ADDR_COUNT, 8'hFF);
        step(1);
        rchk("count", `ADDR_COUNT, 8'hFE);
        step(252);
        pchk(a[0]);
        step(1);
        pchk(~a[0]);
        cf(8'h01, 8'h02);
        step(1);
        cf(8'h00, 8'h03);
        step(1);
        rchk("count", `ADDR_COUNT, 8'h01);
        pchk(~a[0]);
    endtask
    // Synchronous ticks every clock, then the pin released
    task automatic t_sync;
        int n;
        wr_reg(`ADDR_PIN, 8'h01);
        prep(8'h80, 8'hF0);
        set_mode(`MODE_NORMAL, `ACT_NONE, `SEL_DIV1);
        for (n = 0; n < 100 && overflow_flag_r !== 1'h1; n++) @(posedge clk);
        chk("overflow", 8'h01, {7'h00, overflow_flag_r});
        addr <= `ADDR_COUNT;
        wdata <= 8'h40;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk("count", 8'h40, rdata_r);
        @(posedge clk);
        set_mode(`MODE_NORMAL, `ACT_SET, `SEL_STOP);
        wr_reg(`ADDR_CTRL, {1'h1, `SEL_STOP, `ACT_SET, `MODE_NORMAL});
        @(posedge clk);
        pchk(1'h1);
        wr_reg(`ADDR_PIN, 8'h00);
        repeat (2) @(posedge clk);
        chk("enable", 8'h00, {7'h00, pin_oe_r});
        pchk(1'h0);
    endtask
    ////////////////////////////////////////
    task automatic results;
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n = 1'h0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        osc_en = 1'h0;
        bad_count = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        cf(`COUNT_RESET, 8'h00);
        rchk("ctrl", `ADDR_CTRL, `CTRL_RESET);
        rchk("unmapped", 4'hF, 8'h00);
        t_prescale();
        t_normal();
        t_clear();
        t_fast(`ACT_CLEAR);
        t_fast(`ACT_SET);
        t_phase(`ACT_CLEAR);
        t_phase(`ACT_SET);
        t_sync();
        results();
    end
    // Watchdog well beyond the expected run of about 14000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule // tb
